// [design/sbfm_pkg.sv]
// Package with constants and types for the stepper bridge fault monitor
package sbfm_pkg;
  localparam int CLK_MHZ = 10;
  // Short detection delays per code, in ns; code 0 longest, code 3 shortest
  localparam int S2G_DELAY_NS0 = 3200;
  localparam int S2G_DELAY_NS1 = 1600;
  localparam int S2G_DELAY_NS2 = 1200;
  localparam int S2G_DELAY_NS3 = 800;
  localparam logic [7:0] S2G_CYC0 = 8'((S2G_DELAY_NS0 * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] S2G_CYC1 = 8'((S2G_DELAY_NS1 * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] S2G_CYC2 = 8'((S2G_DELAY_NS2 * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] S2G_CYC3 = 8'((S2G_DELAY_NS3 * CLK_MHZ + 999) / 1000);
  localparam int TEMP_WARN_C = 100;
  localparam int TEMP_SHUT_C = 150;
  localparam logic [7:0] TEMP_WARN = 8'(TEMP_WARN_C);
  localparam logic [7:0] TEMP_SHUT = 8'(TEMP_SHUT_C);
  localparam logic [1:0] SHORT_LIMIT = 2'h3;
  localparam logic [4:0] CS_RESET = 5'h00;
  localparam logic [4:0] CUR_MIN_DIV_SHIFT = 5'h04;
  // Gate current codes that get temperature compensation, and the highest code
  localparam logic [1:0] SLP_TC_A = 2'h1;
  localparam logic [1:0] SLP_TC_B = 2'h2;
  localparam logic [1:0] SLP_MAX = 2'h3;
  // Register bus
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
  localparam int CTRL_EN = 0;
  localparam int CTRL_DLY = 1;
  localparam int CTRL_SLPH = 3;
  localparam int CTRL_CS = 5;
  localparam int NUM_EVT = 6;

  typedef struct packed {
    logic shortA;
    logic shortB;
    logic openA;
    logic openB;
    logic prewarn;
    logic overtemp;
  } sbfm_flags_t;

  typedef struct packed {
    logic highOnA;
    logic highOnB;
    logic nodeHighA;
    logic nodeHighB;
    logic polA;
    logic polB;
    logic chopA;
    logic chopB;
  } sbfm_bridge_t;
endpackage

// [design/sbfm_short_phase.sv]
// Short-to-ground detector and short event counter for one phase
`timescale 1ns/100ps
`default_nettype none
module sbfm_short_phase import sbfm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic enable,
  input wire logic [1:0] delaySel,
  // Bridge observation, already synchronised
  input wire logic highOn,
  input wire logic nodeHigh,
  input wire logic polChange,
  input wire logic chopEnd,
  // Results
  output logic shortPulse,
  output logic shortFlag,
  output logic [1:0] count
);
  logic [7:0] timer;
  logic armed;
  logic [1:0] cyclesShort;
  logic [7:0] limit;

  function automatic logic [7:0] delay_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: delay_cycles = S2G_CYC0;
      2'h1: delay_cycles = S2G_CYC1;
      2'h2: delay_cycles = S2G_CYC2;
      default: delay_cycles = S2G_CYC3;
    endcase
  endfunction

  assign limit = delay_cycles(delaySel); // RULE6

  // Node must rise before the delay runs out during high side on time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer <= 8'h00;
      armed <= 1'b0;
      shortPulse <= 1'b0;
    end else begin
      shortPulse <= 1'b0;
      if (!enable || !highOn) begin
        timer <= 8'h00;
        armed <= 1'b1;
      end else if (armed && !nodeHigh) begin
        if (timer + 8'h01 >= limit) begin
          shortPulse <= 1'b1; // RULE5
          armed <= 1'b0;
        end else begin
          timer <= timer + 8'h01;
        end
      end else begin
        armed <= 1'b0;
      end
    end
  end

  // Up on short, down on polarity change, floor at zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 2'h0;
    end else if (!enable) begin
      count <= 2'h0; // RULE15
    end else if (shortPulse && !polChange) begin
      if (count != SHORT_LIMIT) count <= count + 2'h1; // RULE2
    end else if (polChange && !shortPulse && count != 2'h0) begin
      count <= count - 2'h1; // RULE2 RULE15
    end
  end

  // Flag once shorts persist over more than one chopper cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cyclesShort <= 2'h0;
      shortFlag <= 1'b0;
    end else if (!enable) begin
      cyclesShort <= 2'h0;
      shortFlag <= 1'b0; // RULE4
    end else begin
      if (shortPulse && cyclesShort != 2'h3) cyclesShort <= cyclesShort + 2'h1;
      // A clean chopper cycle breaks the run of shorts
      else if (polChange || chopEnd) cyclesShort <= 2'h0;
      if (shortPulse && cyclesShort != 2'h0) shortFlag <= 1'b1; // RULE4
    end
  end
endmodule
`default_nettype wire

// [design/sbfm_top.sv]
// Top of the stepper bridge fault monitor with register port and interrupt
`timescale 1ns/100ps
`default_nettype none
// Operation
// RULE1: Short switches bridge off, ends chopper cycle
// RULE2: Short counter up per short, down per polarity
// RULE3: Counter three shuts driver until re-enable
// RULE4: Persistent short flag per phase, cleared on disable
// RULE5: Short if node low past delay
// RULE6: Delay code zero longest, three shortest
// RULE7: Open coil when no chop in polarity interval
// RULE8: No open update below sixteenth current
// RULE9: Prewarn at 100C, shutdown at 150C
// RULE10: Prewarn flag reads one while warm
// RULE11: Shutdown temperature stops driver, sets flag
// RULE12: Compensated gate codes step up when warm
// RULE13: Undervoltage resets logic, all bridges off
// RULE14: Undervoltage clears current scale to zero
// RULE15: Counter floors at zero, clears on disable
module sbfm_top import sbfm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  output logic irq,
  // Supplies and sensors, asynchronous
  input wire logic logicUvLow,
  input wire logic driverUvLow,
  input wire logic [7:0] tempC,
  // Bridge observation, asynchronous
  input wire sbfm_bridge_t bridgeIn,
  input wire logic [4:0] coilCurA,
  input wire logic [4:0] coilCurB,
  // Driver controls
  output logic driverOn,
  output logic bridgeOffA,
  output logic bridgeOffB,
  output logic chopEndA,
  output logic chopEndB,
  output logic [1:0] highSideSlope
);
  logic [2:0] s1Uv, s2Uv, s3Uv;
  logic uvLevel;
  logic [7:0] tS1, tS2, tS3;
  logic [7:0] tempSync;
  sbfm_bridge_t bS1, bS2, bS3, bSync;
  logic [4:0] cA1, cA2, cA3, cB1, cB2, cB3, curA, curB;
  logic polAPrev, polBPrev, polChgA, polChgB;
  logic ctrlEnable;
  logic [1:0] ctrlDelay, ctrlSlope;
  logic [4:0] ctrlScale;
  logic shortPulseA, shortPulseB, shortFlagA, shortFlagB;
  logic [1:0] cntA, cntB;
  logic shortLatch;
  logic chopSeenA, chopSeenB;
  sbfm_flags_t flags;
  logic [NUM_EVT-1:0] irqStat, irqMask, evt, flagsPrev;
  logic blockReset;
  logic openCoilA, openCoilB, warmFlag, hotFlag;

  // Write strobe aimed at one register
  function automatic logic wr_hit(input logic strobe, input logic [3:0] addr,
                                  input logic [3:0] target);
    wr_hit = strobe && addr == target;
  endfunction

  // Too little current makes a missing chop meaningless
  function automatic logic cur_ok(input logic [4:0] cur, input logic [4:0] scale);
    cur_ok = cur >= (scale >> CUR_MIN_DIV_SHIFT) && cur != 5'h00;
  endfunction

  // Three-stage synchronisers; change taken once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1Uv <= 3'h0;
      s2Uv <= 3'h0;
      s3Uv <= 3'h0;
      tS1 <= 8'h00;
      tS2 <= 8'h00;
      tS3 <= 8'h00;
      bS1 <= '0;
      bS2 <= '0;
      bS3 <= '0;
      cA1 <= 5'h00;
      cA2 <= 5'h00;
      cA3 <= 5'h00;
      cB1 <= 5'h00;
      cB2 <= 5'h00;
      cB3 <= 5'h00;
    end else begin
      s1Uv <= {logicUvLow, driverUvLow, 1'b0};
      s2Uv <= s1Uv;
      s3Uv <= s2Uv;
      tS1 <= tempC;
      tS2 <= tS1;
      tS3 <= tS2;
      bS1 <= bridgeIn;
      bS2 <= bS1;
      bS3 <= bS2;
      cA1 <= coilCurA;
      cA2 <= cA1;
      cA3 <= cA2;
      cB1 <= coilCurB;
      cB2 <= cB1;
      cB3 <= cB2;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      uvLevel <= 1'b0;
      tempSync <= 8'h00;
      bSync <= '0;
      curA <= 5'h00;
      curB <= 5'h00;
    end else begin
      if (s2Uv == s3Uv) uvLevel <= |s3Uv;
      if (tS2 == tS3) tempSync <= tS3;
      if (bS2 == bS3) bSync <= bS3;
      if (cA2 == cA3) curA <= cA3;
      if (cB2 == cB3) curB <= cB3;
    end
  end

  assign blockReset = uvLevel; // RULE13

  // Polarity change pulses
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      polAPrev <= 1'b0;
      polBPrev <= 1'b0;
      polChgA <= 1'b0;
      polChgB <= 1'b0;
    end else begin
      polAPrev <= bSync.polA;
      polBPrev <= bSync.polB;
      polChgA <= bSync.polA ^ polAPrev;
      polChgB <= bSync.polB ^ polBPrev;
    end
  end

  // Control register; undervoltage returns it to defaults
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlEnable <= 1'b0;
      ctrlDelay <= 2'h0;
      ctrlSlope <= 2'h0;
      ctrlScale <= CS_RESET;
    end else if (blockReset) begin
      ctrlEnable <= 1'b0; // RULE13
      ctrlDelay <= 2'h0;
      ctrlSlope <= 2'h0;
      ctrlScale <= CS_RESET; // RULE14
    end else if (wr_hit(regWrite, regAddr, ADDR_CTRL)) begin
      ctrlEnable <= regWdata[CTRL_EN];
      ctrlDelay <= regWdata[CTRL_DLY +: 2];
      ctrlSlope <= regWdata[CTRL_SLPH +: 2];
      ctrlScale <= regWdata[CTRL_CS +: 5];
    end
  end

  sbfm_short_phase uShortA (
    .clk(clk),
    .reset_n(reset_n),
    .enable(ctrlEnable),
    .delaySel(ctrlDelay),
    .highOn(bSync.highOnA),
    .nodeHigh(bSync.nodeHighA),
    .polChange(polChgA),
    .chopEnd(bSync.chopA),
    .shortPulse(shortPulseA),
    .shortFlag(shortFlagA),
    .count(cntA)
  );
  sbfm_short_phase uShortB (
    .clk(clk),
    .reset_n(reset_n),
    .enable(ctrlEnable),
    .delaySel(ctrlDelay),
    .highOn(bSync.highOnB),
    .nodeHigh(bSync.nodeHighB),
    .polChange(polChgB),
    .chopEnd(bSync.chopB),
    .shortPulse(shortPulseB),
    .shortFlag(shortFlagB),
    .count(cntB)
  );

  // Persistent short shutdown held until the driver is re-enabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) shortLatch <= 1'b0;
    else if (!ctrlEnable) shortLatch <= 1'b0;
    else if (cntA == SHORT_LIMIT || cntB == SHORT_LIMIT) shortLatch <= 1'b1; // RULE3
  end

  // Open coil: watch for a chopper event inside each polarity interval
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chopSeenA <= 1'b0;
      chopSeenB <= 1'b0;
      openCoilA <= 1'b0;
      openCoilB <= 1'b0;
    end else if (blockReset) begin
      chopSeenA <= 1'b0;
      chopSeenB <= 1'b0;
      openCoilA <= 1'b0;
      openCoilB <= 1'b0;
    end else begin
      chopSeenA <= polChgA ? 1'b0 : (chopSeenA | bSync.chopA);
      chopSeenB <= polChgB ? 1'b0 : (chopSeenB | bSync.chopB);
      if (polChgA && cur_ok(curA, ctrlScale))
        openCoilA <= !chopSeenA; // RULE7 RULE8
      if (polChgB && cur_ok(curB, ctrlScale))
        openCoilB <= !chopSeenB; // RULE7 RULE8
    end
  end

  // Temperature flags; shutdown sticks until disable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      warmFlag <= 1'b0;
      hotFlag <= 1'b0;
    end else begin
      warmFlag <= tempSync >= TEMP_WARN; // RULE9 RULE10
      if (!ctrlEnable) hotFlag <= 1'b0;
      else if (tempSync >= TEMP_SHUT) hotFlag <= 1'b1; // RULE9 RULE11
    end
  end

  // One writer for the whole flag word
  always_comb begin
    flags.shortA = shortFlagA;
    flags.shortB = shortFlagB;
    flags.openA = openCoilA;
    flags.openB = openCoilB;
    flags.prewarn = warmFlag;
    flags.overtemp = hotFlag;
  end

  // Driver outputs, all from flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      driverOn <= 1'b0;
      bridgeOffA <= 1'b1;
      bridgeOffB <= 1'b1;
      chopEndA <= 1'b0;
      chopEndB <= 1'b0;
    end else begin
      driverOn <= ctrlEnable && !blockReset && !shortLatch && !flags.overtemp; // RULE3 RULE11
      bridgeOffA <= blockReset || !ctrlEnable || shortLatch || flags.overtemp
                    || shortPulseA; // RULE1 RULE13
      bridgeOffB <= blockReset || !ctrlEnable || shortLatch || flags.overtemp
                    || shortPulseB; // RULE1 RULE13
      chopEndA <= shortPulseA; // RULE1
      chopEndB <= shortPulseB; // RULE1
    end
  end

  // Gate current with temperature compensation on the two marked codes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) highSideSlope <= 2'h0;
    else if (flags.prewarn && (ctrlSlope == SLP_TC_A || ctrlSlope == SLP_TC_B)
             && ctrlSlope != SLP_MAX)
      highSideSlope <= ctrlSlope + 2'h1; // RULE12
    else highSideSlope <= ctrlSlope;
  end

  // Interrupts on rising flags; set wins over write-one-to-clear
  assign evt = flags & ~flagsPrev;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flagsPrev <= '0;
      irqStat <= '0;
      irqMask <= '0;
      irq <= 1'b0;
    end else begin
      flagsPrev <= flags;
      if (wr_hit(regWrite, regAddr, ADDR_IRQ_STAT))
        irqStat <= (irqStat & ~regWdata[NUM_EVT-1:0]) | evt;
      else
        irqStat <= irqStat | evt;
      if (wr_hit(regWrite, regAddr, ADDR_IRQ_MASK)) irqMask <= regWdata[NUM_EVT-1:0];
      irq <= |(irqStat & irqMask);
    end
  end

  // Read port, data in the cycle after the strobe only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) regRdata <= 16'h0000;
    else if (regRead) begin
      case (regAddr)
        ADDR_CTRL: regRdata <= {6'h00, ctrlScale, ctrlSlope, ctrlDelay, ctrlEnable}; // RULE14
        ADDR_STATUS: regRdata <= {4'h0, driverOn, shortLatch, cntB, cntA, flags};
        ADDR_IRQ_STAT: regRdata <= {10'h000, irqStat};
        ADDR_IRQ_MASK: regRdata <= {10'h000, irqMask};
        default: regRdata <= 16'h0000;
      endcase
    end else regRdata <= 16'h0000;
  end
endmodule
`default_nettype wire

// [sim/sbfm_bridge_model.sv]
// Behavioural model of the two power bridges and motor coils
`timescale 1ns/100ps
`default_nettype none
module sbfm_bridge_model import sbfm_pkg::*; (
  // Clock
  input wire logic clk,
  // Bench commands, bit 0 phase A, bit 1 phase B
  input wire logic [1:0] hiCmd,
  input wire logic [1:0] shorted,
  input wire logic [1:0] pol,
  input wire logic [1:0] chop,
  // Design controls
  input wire logic bridgeOffA,
  input wire logic bridgeOffB,
  // Bridge levels seen by the design
  output var sbfm_bridge_t bridgeOut
);
  logic [1:0] highOn;
  logic [1:0] slope0 = 2'h0;
  logic [1:0] slope1 = 2'h0;
  // Forced-off bridge cannot conduct
  assign highOn = hiCmd & ~{bridgeOffB, bridgeOffA};
  // Node needs two cycles of slope; a short keeps it low
  always_ff @(posedge clk) begin
    slope0 <= highOn & ~shorted;
    slope1 <= slope0 & highOn & ~shorted;
  end
  assign bridgeOut = sbfm_bridge_t'({highOn[0], highOn[1], slope1[0], slope1[1],
                                     pol[0], pol[1], chop[0], chop[1]});
endmodule
`default_nettype wire

// [sim/sbfm_assertions.sv]
// Port-level assertions for the fault monitor top
`timescale 1ns/100ps
`default_nettype none
module sbfm_assertions import sbfm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic regRead,
  input wire logic [15:0] regRdata,
  input wire logic irq,
  // Supplies, sensors, bridges
  input wire logic logicUvLow,
  input wire logic driverUvLow,
  input wire logic [7:0] tempC,
  input wire sbfm_bridge_t bridgeIn,
  // Driver controls
  input wire logic driverOn,
  input wire logic bridgeOffA,
  input wire logic bridgeOffB,
  input wire logic chopEndA,
  input wire logic chopEndB
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_pulse_a; chopEndA |=> !chopEndA; endproperty
  a_pulse_a: assert property (p_pulse_a) else $error("chopEndA too long");
  property p_pulse_b; chopEndB |=> !chopEndB; endproperty
  a_pulse_b: assert property (p_pulse_b) else $error("chopEndB too long");
  property p_off_a; chopEndA |-> bridgeOffA; endproperty
  a_off_a: assert property (p_off_a) else $error("bridge A not off");
  property p_off_b; chopEndB |-> bridgeOffB; endproperty
  a_off_b: assert property (p_off_b) else $error("bridge B not off");
  // Eight cycles back lies inside every detection window
  property p_cause_a;
    chopEndA |-> $past(bridgeIn.highOnA, 8) && !$past(bridgeIn.nodeHighA, 8);
  endproperty
  a_cause_a: assert property (p_cause_a) else $error("short without cause");
  property p_uv;
    (logicUvLow || driverUvLow) [*8] |-> !driverOn && bridgeOffA && bridgeOffB;
  endproperty
  a_uv: assert property (p_uv) else $error("driver on in undervoltage");
  property p_hot; (tempC >= TEMP_SHUT) [*8] |-> !driverOn; endproperty
  a_hot: assert property (p_hot) else $error("driver on when hot");
  property p_rdata; !$past(regRead) |-> regRdata == 16'h0000; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  c_short: cover property (chopEndA);
  c_shut: cover property ($fell(driverOn));
  c_irq: cover property ($rose(irq));
endmodule
bind sbfm_top sbfm_assertions u_chk (.clk, .reset_n, .regRead, .regRdata, .irq, .logicUvLow,
  .driverUvLow, .tempC, .bridgeIn, .driverOn, .bridgeOffA, .bridgeOffB, .chopEndA, .chopEndB);
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the stepper bridge fault monitor
`timescale 1ns/100ps
`default_nettype none
module testbench import sbfm_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic logicUvLow = 1'b0;
  logic driverUvLow = 1'b0;
  logic [7:0] tempC = 8'h19;
  logic [4:0] coilCurA = 5'h00;
  logic [4:0] coilCurB = 5'h00;
  logic [1:0] hiCmd = 2'h0;
  logic [1:0] shorted = 2'h0;
  logic [1:0] pol = 2'h0;
  logic [1:0] chop = 2'h0;
  logic [15:0] regRdata;
  logic irq, driverOn, bridgeOffA, bridgeOffB, chopEndA, chopEndB;
  logic [1:0] highSideSlope;
  sbfm_bridge_t bridgeIn;
  int errTotal = 0;
  int nTests = 0;
  int dly [4] = '{int'(S2G_CYC0), int'(S2G_CYC1), int'(S2G_CYC2), int'(S2G_CYC3)};
  sbfm_top uut (.clk, .reset_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq,
    .logicUvLow, .driverUvLow, .tempC, .bridgeIn, .coilCurA, .coilCurB, .driverOn,
    .bridgeOffA, .bridgeOffB, .chopEndA, .chopEndB, .highSideSlope);
  sbfm_bridge_model partner (.clk, .hiCmd, .shorted, .pol, .chop, .bridgeOffA, .bridgeOffB,
    .bridgeOut(bridgeIn));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic wrapUp();
    $display("comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  // Read data is taken at the edge closing its one-cycle slot
  task automatic chkReg(input string what, input logic [3:0] a, input logic [15:0] m,
                        input logic [15:0] exp);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    chk(what, exp, regRdata & m);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic shortRun(input int idx, input int lo);
    int n;
    n = 0;
    shorted[idx] <= 1'b1;
    hiCmd[idx] <= 1'b1;
    while ((idx == 0 ? chopEndA : chopEndB) !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 200) begin
        errTotal++;
        $display("unexpected timeout waiting for short");
        wrapUp();
      end
    end
    hiCmd[idx] <= 1'b0;
    chk("short delay ok", 16'h0001, 16'(n >= lo && n <= lo + 12));
    pause(8);
  endtask
  task automatic flip(input int idx);
    pol[idx] <= ~pol[idx];
    pause(10);
  endtask
  task automatic chopPulse();
    chop[0] <= 1'b1;
    pause(8);
    chop[0] <= 1'b0;
    pause(8);
  endtask
  initial begin
    pause(3);
    chk("reset outputs", 16'h0003, {13'h0, driverOn, bridgeOffA, bridgeOffB});
    reset_n <= 1'b1;
    @(posedge clk);
    chkReg("unmapped", 4'h2, 16'hFFFF, 16'h0000);
    wr(ADDR_CTRL, 16'h0209);
    chkReg("control", ADDR_CTRL, 16'h03FF, 16'h0209);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL, 16'h0209 | 16'(c << 1));
      shortRun(0, dly[c]);
      chkReg("count up", ADDR_STATUS, 16'h00C0, 16'h0040);
      flip(0);
      chkReg("count down", ADDR_STATUS, 16'h00C0, 16'h0000);
    end
    flip(0);
    chkReg("count floor", ADDR_STATUS, 16'h00C0, 16'h0000);
    shortRun(1, dly[3]);
    chkReg("count B", ADDR_STATUS, 16'h0300, 16'h0100);
    $display("done: detection");
    repeat (3) shortRun(0, dly[3]);
    chk("driver shut", 16'h0000, {15'h0, driverOn});
    chkReg("short status", ADDR_STATUS, 16'h0CE0, 16'h04E0);
    wr(ADDR_CTRL, 16'h020E);
    chkReg("cleared", ADDR_STATUS, 16'h0FF0, 16'h0000);
    wr(ADDR_CTRL, 16'h020F);
    pause(2);
    chk("driver back", 16'h0001, {15'h0, driverOn});
    $display("done: shutdown");
    shorted <= 2'h0;
    coilCurA <= 5'h01;
    flip(0);
    flip(0);
    chkReg("open set", ADDR_STATUS, 16'h0008, 16'h0008);
    coilCurA <= 5'h00;
    chopPulse();
    flip(0);
    chkReg("open held", ADDR_STATUS, 16'h0008, 16'h0008);
    coilCurA <= 5'h01;
    chopPulse();
    flip(0);
    chkReg("open clear", ADDR_STATUS, 16'h0008, 16'h0000);
    $display("done: open coil");
    tempC <= TEMP_WARN - 8'h01;
    wr(ADDR_IRQ_STAT, 16'h003F);
    chkReg("cool", ADDR_STATUS, 16'h0002, 16'h0000);
    chk("slope cool", 16'h0001, {14'h0, highSideSlope});
    tempC <= TEMP_WARN;
    pause(10);
    chkReg("prewarn", ADDR_STATUS, 16'h0002, 16'h0002);
    chk("slope warm", 16'h0002, {14'h0, highSideSlope});
    wr(ADDR_CTRL, 16'h0217);
    pause(2);
    chk("slope code 2", 16'h0003, {14'h0, highSideSlope});
    wr(ADDR_CTRL, 16'h0207);
    pause(2);
    chk("slope code 0", 16'h0000, {14'h0, highSideSlope});
    chkReg("event", ADDR_IRQ_STAT, 16'h0002, 16'h0002);
    chk("irq masked", 16'h0000, {15'h0, irq});
    wr(ADDR_IRQ_MASK, 16'h0002);
    pause(2);
    chk("irq raised", 16'h0001, {15'h0, irq});
    wr(ADDR_IRQ_STAT, 16'h0002);
    pause(2);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    tempC <= TEMP_SHUT;
    pause(10);
    chk("hot off", 16'h0000, {15'h0, driverOn});
    chkReg("overtemp", ADDR_STATUS, 16'h0001, 16'h0001);
    tempC <= 8'h19;
    $display("done: temperature");
    driverUvLow <= 1'b1;
    pause(10);
    chk("uv outputs", 16'h0003, {14'h0, bridgeOffA, bridgeOffB});
    driverUvLow <= 1'b0;
    pause(10);
    chkReg("scale after uv", ADDR_CTRL, 16'h03FF, 16'h0000);
    $display("done: undervoltage");
    wrapUp();
  end
endmodule
`default_nettype wire
